/* apr_addr_dec.sv */
// Purpose: Decode the programming port address into one-hot register selects
// Assumes: Port inputs synchronous to the clock
// Notes: Unmapped addresses select nothing
`timescale 1ns/1ns
`include "apr_cfg.svh"
module apr_addr_dec (
   // Programming port
   input wire apr_pkg::apr_addr_t addr,
   input wire logic wr_en,
   input wire apr_pkg::apr_byte_t wdata,
   // Write carrier
   apr_wr_if.dec wr_bus
);
   always_comb begin
      wr_bus.sel = 4'h0;
      case (addr)
         `APR_ADDR_LOOP_FILTER: wr_bus.sel = 4'h1;
         `APR_ADDR_LOCK_MODE: wr_bus.sel = 4'h2;
         `APR_ADDR_VCO_ONE: wr_bus.sel = 4'h4;
         `APR_ADDR_VCO_TWO: wr_bus.sel = 4'h8;
         default: wr_bus.sel = 4'h0;
      endcase
      wr_bus.wr = wr_en;
      wr_bus.data = wdata;
   end
endmodule

/* apr_byte_reg.sv */
// Purpose: One writable configuration byte with a reset value
// Assumes: Synchronous active-high reset
// Notes: Reserved bits are stored like any other and read back as written
`timescale 1ns/1ns
module apr_byte_reg #(
   parameter int IDX = 0,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write carrier
   apr_wr_if.reg_side wr_bus,
   // Stored value
   output apr_pkg::apr_byte_t value
);
   apr_pkg::apr_byte_t next_value;

   always_comb begin
      next_value = value;
      if (rst) begin
         next_value = RST_VAL;
      end else if (wr_bus.wr && wr_bus.sel[IDX]) begin
         next_value = wr_bus.data;
      end
   end

   always_ff @(posedge clk) begin
      value <= next_value;
   end
endmodule

/* apr_cfg.svh */
// Purpose: Offsets, field positions and reset values of the analog loop 0 register bank
// Assumes: Byte-wide registers on a byte-addressed programming port
// Notes: Definitions only
`ifndef APR_CFG_SVH
`define APR_CFG_SVH
// -----------------------------------------------------------------
// Offsets
// -----------------------------------------------------------------
`define APR_ADDR_LOOP_FILTER 16'h00ac
`define APR_ADDR_LOCK_MODE 16'h00ad
`define APR_ADDR_VCO_ONE 16'h00ae
`define APR_ADDR_VCO_TWO 16'h00af
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define APR_CP_CUR_LSB 5
`define APR_SER_RES_LSB 3
`define APR_PAR_CAP_LSB 1
`define APR_POLE_BIT 0
`define APR_SYNTH_BIT 3
`define APR_ACC_BIT 1
`define APR_OVR_BIT 0
`define APR_VCO_PICK_BIT 5
`define APR_CODE_LSB 0
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define APR_RST_CP_CUR 3'h4
`define APR_RST_SER_RES 2'h1
`define APR_RST_PAR_CAP 2'h1
`define APR_RST_POLE 1'h1
`define APR_RST_ACC 1'h1
`define APR_RST_OVR 1'h0
`define APR_RST_VCO_PICK 1'h1
`define APR_RST_SYNTH 1'h0
`define APR_RST_CODE_ONE 5'h0b
`define APR_RST_CODE_TWO 5'h00
`endif

/* apr_pkg.sv */
// Purpose: Types shared by the analog loop 0 register bank
// Assumes: Nothing
// Notes: Constants live in apr_cfg.svh
package apr_pkg;
   typedef logic [7:0] apr_byte_t;
   typedef logic [15:0] apr_addr_t;
   typedef enum logic {APR_AUTO_LOCK, APR_MANUAL_LOCK} apr_lock_e;
endpackage

/* apr_pll_a_regs.sv */
// Purpose: Analog loop 0 control register bank behind the host programming port
// Assumes: Host port gives address, write strobe, write data; reads are registered
// Notes: Fields drive the analog loop continuously; no side effects on access
//
// Behaviour
// - Three-bit charge pump current select, reset 100b, 110uA to 880uA steps.
// - Two-bit loop series resistor select, reset 01b, 330 ohm to 1.79k.
// - Two-bit loop parallel capacitor select, reset 01b, 40pF to 200pF.
// - Second pole select, reset 1: 0 picks 497 ohm, 1 picks 1.58k.
// - Lock count accuracy bit, reset 1: 0 is 1 ppm, 1 is 16 ppm.
// - Lock override mode bit, reset 0: 0 automatic, 1 manual.
// - Manual VCO pick bit, reset 1: 0 second VCO, 1 first VCO.
// - First VCO manual lock code, five bits, reset 01011b, applied in manual.
// - Second VCO manual lock code, five bits, reset 00000b, applied in manual.
// - Synth only mode bit, reset 0: 1 uses crystal reference only.
// - Reserved bits may read any value; do not check them.
`timescale 1ns/1ns
`include "apr_cfg.svh"
module apr_pll_a_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Host programming port
   input wire apr_pkg::apr_addr_t ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire apr_pkg::apr_byte_t WDATA,
   output apr_pkg::apr_byte_t RDATA,
   output logic RVALID,
   // Loop filter settings
   output logic [2:0] CHARGE_PUMP_CURRENT_SEL,
   output logic [1:0] LOOP_SERIES_RESISTOR_SEL,
   output logic [1:0] LOOP_PARALLEL_CAP_SEL,
   output logic SECOND_POLE_SEL,
   // Lock control
   output logic LOCK_COUNT_ACCURACY,
   output logic LOCK_OVERRIDE_MODE,
   output logic MANUAL_VCO_PICK,
   output logic [4:0] VCO_ONE_MANUAL_LOCK_CODE,
   output logic [4:0] VCO_TWO_MANUAL_LOCK_CODE,
   output logic [4:0] APPLIED_LOCK_CODE,
   output logic MANUAL_LOCK_ACTIVE,
   // Operating mode
   output logic SYNTH_ONLY_MODE
);
   // -----------------------------------------------------------------
   // Reset images of the four bytes
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_LOOP_FILTER = {`APR_RST_CP_CUR, `APR_RST_SER_RES,
      `APR_RST_PAR_CAP, `APR_RST_POLE};
   localparam logic [7:0] RST_LOCK_MODE = {4'h0, `APR_RST_SYNTH, 1'b0,
      `APR_RST_ACC, `APR_RST_OVR};
   localparam logic [7:0] RST_VCO_ONE = {2'h0, `APR_RST_VCO_PICK,
      `APR_RST_CODE_ONE};
   localparam logic [7:0] RST_VCO_TWO = {3'h0, `APR_RST_CODE_TWO};

   apr_wr_if wr_bus ();
   apr_pkg::apr_byte_t reg_loop_filter;
   apr_pkg::apr_byte_t reg_lock_mode;
   apr_pkg::apr_byte_t reg_vco_one;
   apr_pkg::apr_byte_t reg_vco_two;
   apr_pkg::apr_byte_t next_rdata;
   logic next_rvalid;
   apr_pkg::apr_lock_e lock_kind;
   apr_pkg::apr_byte_t next_lock_mode;
   apr_pkg::apr_byte_t next_vco_one;
   apr_pkg::apr_byte_t next_vco_two;
   logic next_manual_active;
   logic [4:0] next_applied_code;

   // -----------------------------------------------------------------
   // Decode and storage
   // -----------------------------------------------------------------
   apr_addr_dec u_dec (
      .addr(ADDR),
      .wr_en(WR_EN),
      .wdata(WDATA),
      .wr_bus(wr_bus)
   );

   // Reserved bits are stored as written, so reads return what software put there
   apr_byte_reg #(.IDX(0), .RST_VAL(RST_LOOP_FILTER)) u_loop_filter (
      .clk(CLK),
      .rst(RST),
      .wr_bus(wr_bus),
      .value(reg_loop_filter)
   );
   apr_byte_reg #(.IDX(1), .RST_VAL(RST_LOCK_MODE)) u_lock_mode (
      .clk(CLK),
      .rst(RST),
      .wr_bus(wr_bus),
      .value(reg_lock_mode)
   );
   apr_byte_reg #(.IDX(2), .RST_VAL(RST_VCO_ONE)) u_vco_one (
      .clk(CLK),
      .rst(RST),
      .wr_bus(wr_bus),
      .value(reg_vco_one)
   );
   apr_byte_reg #(.IDX(3), .RST_VAL(RST_VCO_TWO)) u_vco_two (
      .clk(CLK),
      .rst(RST),
      .wr_bus(wr_bus),
      .value(reg_vco_two)
   );

   // -----------------------------------------------------------------
   // Field outputs to the analog loop
   // -----------------------------------------------------------------
   assign CHARGE_PUMP_CURRENT_SEL = reg_loop_filter[`APR_CP_CUR_LSB +: 3];
   assign LOOP_SERIES_RESISTOR_SEL = reg_loop_filter[`APR_SER_RES_LSB +: 2];
   assign LOOP_PARALLEL_CAP_SEL = reg_loop_filter[`APR_PAR_CAP_LSB +: 2];
   assign SECOND_POLE_SEL = reg_loop_filter[`APR_POLE_BIT];
   assign LOCK_COUNT_ACCURACY = reg_lock_mode[`APR_ACC_BIT];
   assign LOCK_OVERRIDE_MODE = reg_lock_mode[`APR_OVR_BIT];
   assign SYNTH_ONLY_MODE = reg_lock_mode[`APR_SYNTH_BIT];
   assign MANUAL_VCO_PICK = reg_vco_one[`APR_VCO_PICK_BIT];
   assign VCO_ONE_MANUAL_LOCK_CODE = reg_vco_one[`APR_CODE_LSB +: 5];
   assign VCO_TWO_MANUAL_LOCK_CODE = reg_vco_two[`APR_CODE_LSB +: 5];

   // -----------------------------------------------------------------
   // Manual lock code steering
   // -----------------------------------------------------------------
   // In automatic mode the code output is zero so the analog side never sees a stale code.
   // Steering works on the bytes' next values and is registered, so the code is a clean
   // flop output that moves on the same edge as the fields it is built from.
   always_comb begin
      next_lock_mode = reg_lock_mode;
      next_vco_one = reg_vco_one;
      next_vco_two = reg_vco_two;
      if (RST) begin
         next_lock_mode = RST_LOCK_MODE;
         next_vco_one = RST_VCO_ONE;
         next_vco_two = RST_VCO_TWO;
      end else if (wr_bus.wr) begin
         if (wr_bus.sel[1]) begin
            next_lock_mode = wr_bus.data;
         end
         if (wr_bus.sel[2]) begin
            next_vco_one = wr_bus.data;
         end
         if (wr_bus.sel[3]) begin
            next_vco_two = wr_bus.data;
         end
      end
      lock_kind = apr_pkg::apr_lock_e'(next_lock_mode[`APR_OVR_BIT]);
      next_manual_active = 1'b0;
      next_applied_code = 5'h00;
      case (lock_kind)
         apr_pkg::APR_MANUAL_LOCK: begin
            next_manual_active = 1'b1;
            if (next_vco_one[`APR_VCO_PICK_BIT]) begin
               next_applied_code = next_vco_one[`APR_CODE_LSB +: 5];
            end else begin
               next_applied_code = next_vco_two[`APR_CODE_LSB +: 5];
            end
         end
         default: begin
            next_manual_active = 1'b0;
            next_applied_code = 5'h00;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      MANUAL_LOCK_ACTIVE <= next_manual_active;
      APPLIED_LOCK_CODE <= next_applied_code;
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   always_comb begin
      next_rdata = RDATA;
      next_rvalid = 1'b0;
      if (RST) begin
         next_rdata = 8'h00;
      end else if (RD_EN) begin
         next_rvalid = 1'b1;
         case (ADDR)
            `APR_ADDR_LOOP_FILTER: next_rdata = reg_loop_filter;
            `APR_ADDR_LOCK_MODE: next_rdata = reg_lock_mode;
            `APR_ADDR_VCO_ONE: next_rdata = reg_vco_one;
            `APR_ADDR_VCO_TWO: next_rdata = reg_vco_two;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      RDATA <= next_rdata;
      RVALID <= next_rvalid;
   end
endmodule

/* apr_regs_monitor.sv */
// Purpose: Port-level checks on the analog loop 0 register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Reserved read bits are never checked
`timescale 1ns/1ns
module apr_regs_monitor (
   // Clock, reset, host port
   input wire logic CLK,
   input wire logic RST,
   input wire apr_pkg::apr_addr_t ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire apr_pkg::apr_byte_t WDATA,
   input wire apr_pkg::apr_byte_t RDATA,
   input wire logic RVALID,
   // Field outputs
   input wire logic [2:0] CHARGE_PUMP_CURRENT_SEL,
   input wire logic [1:0] LOOP_SERIES_RESISTOR_SEL,
   input wire logic [1:0] LOOP_PARALLEL_CAP_SEL,
   input wire logic SECOND_POLE_SEL,
   input wire logic LOCK_COUNT_ACCURACY,
   input wire logic LOCK_OVERRIDE_MODE,
   input wire logic MANUAL_VCO_PICK,
   input wire logic [4:0] VCO_ONE_MANUAL_LOCK_CODE,
   input wire logic [4:0] VCO_TWO_MANUAL_LOCK_CODE,
   input wire logic [4:0] APPLIED_LOCK_CODE,
   input wire logic MANUAL_LOCK_ACTIVE,
   input wire logic SYNTH_ONLY_MODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   wire [7:0] flt = {CHARGE_PUMP_CURRENT_SEL, LOOP_SERIES_RESISTOR_SEL,
      LOOP_PARALLEL_CAP_SEL, SECOND_POLE_SEL};
   wire [7:0] mode = {4'h0, SYNTH_ONLY_MODE, 1'b0, LOCK_COUNT_ACCURACY, LOCK_OVERRIDE_MODE};
   wire [7:0] one = {2'b00, MANUAL_VCO_PICK, VCO_ONE_MANUAL_LOCK_CODE};
   sequence s_wr(a); WR_EN && ADDR == a; endsequence
   // A write in the same cycle would move the fields under the read
   sequence s_rd(a); RD_EN && !WR_EN && ADDR == a; endsequence
   a_reset_defaults: assert property ($fell(RST) |-> flt == 8'h8b && mode == 8'h02
      && one == 8'h2b && VCO_TWO_MANUAL_LOCK_CODE == 5'h00 && RDATA == 8'h00)
      else $error("field defaults wrong after reset");
   a_filter_write: assert property (s_wr(16'h00ac) |=> flt == $past(WDATA))
      else $error("filter fields did not take the write");
   a_mode_write: assert property (s_wr(16'h00ad) |=> mode == ($past(WDATA) & 8'h0b))
      else $error("mode fields did not take the write");
   a_vco_one_write: assert property (s_wr(16'h00ae) |=> one == ($past(WDATA) & 8'h3f))
      else $error("first oscillator fields did not take the write");
   a_vco_two_write: assert property (s_wr(16'h00af) |=>
      VCO_TWO_MANUAL_LOCK_CODE == $past(WDATA[4:0])) else $error("second code not written");
   a_fields_hold: assert property (!WR_EN |=> $stable({flt, mode, one,
      VCO_TWO_MANUAL_LOCK_CODE})) else $error("fields moved without a write");
   a_read_pulse: assert property (RD_EN |=> RVALID) else $error("read not answered");
   a_read_idle: assert property (!RD_EN |=> !RVALID && $stable(RDATA))
      else $error("read answer without a read");
   a_filter_read: assert property (s_rd(16'h00ac) |=> RDATA == flt)
      else $error("filter readback wrong");
   a_unmapped_read: assert property (s_rd(16'h00b0) |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_applied_code: assert property (MANUAL_LOCK_ACTIVE == LOCK_OVERRIDE_MODE
      && APPLIED_LOCK_CODE == (!LOCK_OVERRIDE_MODE ? 5'h00 : MANUAL_VCO_PICK ?
      VCO_ONE_MANUAL_LOCK_CODE : VCO_TWO_MANUAL_LOCK_CODE)) else $error("applied code wrong");
endmodule
bind apr_pll_a_regs apr_regs_monitor u_mon (.*);

/* apr_wr_if.sv */
// Purpose: Write strobe and data carried from the decoder to the byte registers
// Assumes: One clock domain
// Notes: Internal carrier only
`timescale 1ns/1ns
interface apr_wr_if;
   logic [3:0] sel;
   logic wr;
   apr_pkg::apr_byte_t data;
   modport dec (output sel, output wr, output data);
   modport reg_side (input sel, input wr, input data);
endinterface

/* tb.sv */
// Purpose: Directed bench for the analog loop 0 register bank
// Assumes: Reads answer one cycle after the strobe
// Notes: Reserved bits are written as zero and masked on read
`timescale 1ns/1ns
module tb;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic WR_EN = 1'b0;
   logic RD_EN = 1'b0;
   apr_pkg::apr_addr_t ADDR = 16'h0000;
   apr_pkg::apr_byte_t WDATA = 8'h00;
   apr_pkg::apr_byte_t RDATA;
   logic RVALID, SECOND_POLE_SEL, LOCK_COUNT_ACCURACY, LOCK_OVERRIDE_MODE;
   logic MANUAL_VCO_PICK, MANUAL_LOCK_ACTIVE, SYNTH_ONLY_MODE;
   logic [2:0] CHARGE_PUMP_CURRENT_SEL;
   logic [1:0] LOOP_SERIES_RESISTOR_SEL, LOOP_PARALLEL_CAP_SEL;
   logic [4:0] VCO_ONE_MANUAL_LOCK_CODE, VCO_TWO_MANUAL_LOCK_CODE, APPLIED_LOCK_CODE;
   int failures = 0;
   int comparisons = 0;
   logic [7:0] ex [4];
   logic [7:0] rdv;
   localparam logic [7:0] MASK [4] = '{8'hff, 8'h0b, 8'h3f, 8'h1f};
   localparam logic [7:0] DEFV [4] = '{8'h8b, 8'h02, 8'h2b, 8'h00};
   apr_pll_a_regs u_dut (.*);
   always #5 CLK = ~CLK;
   // -----------------------------------------------------------------
   // Bus and compare helpers
   // -----------------------------------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One cycle on the host port; strobes stay as set until the next call
   task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
      ADDR = a;
      WDATA = d;
      WR_EN = w;
      RD_EN = r;
      @(posedge CLK);
      #1;
      rdv = RDATA;
      if (r) cmp8({7'h00, RVALID}, 8'h01);
   endtask
   task automatic wr(input int r, input logic [7:0] d);
      bus(16'h00ac + 16'(r), d, 1'b1, 1'b0);
      ex[r] = d;
   endtask
   task automatic chk_all();
      logic [4:0] code;
      code = !ex[1][0] ? 5'h00 : ex[2][5] ? ex[2][4:0] : ex[3][4:0];
      cmp8({CHARGE_PUMP_CURRENT_SEL, LOOP_SERIES_RESISTOR_SEL, LOOP_PARALLEL_CAP_SEL,
         SECOND_POLE_SEL}, ex[0]);
      cmp8({4'h0, SYNTH_ONLY_MODE, 1'b0, LOCK_COUNT_ACCURACY, LOCK_OVERRIDE_MODE},
         ex[1] & MASK[1]);
      cmp8({2'b00, MANUAL_VCO_PICK, VCO_ONE_MANUAL_LOCK_CODE}, ex[2] & MASK[2]);
      cmp8({3'b000, VCO_TWO_MANUAL_LOCK_CODE}, ex[3] & MASK[3]);
      cmp8({2'b00, MANUAL_LOCK_ACTIVE, APPLIED_LOCK_CODE}, {2'b00, ex[1][0], code});
      for (int r = 0; r < 4; r++) begin
         bus(16'h00ac + 16'(r), 8'h00, 1'b0, 1'b1);
         cmp8(rdv & MASK[r], ex[r] & MASK[r]);
      end
      bus(16'h0000, 8'h00, 1'b0, 1'b0);
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_defaults();
      ex = DEFV;
      chk_all();
   endtask
   // Every code of every field but the five-bit lock codes, which see 8 of 32; the pattern also pairs manual mode with both picks
   task automatic t_codes();
      logic [2:0] i;
      for (int n = 0; n < 8; n++) begin
         i = 3'(n);
         for (int r = 0; r < 4; r++) wr(r, {i[0], i, i[1], i} & MASK[r]);
         chk_all();
      end
   endtask
   // A single set bit per byte tells apart fields that the counting pattern moves together
   task automatic t_walk();
      for (int b = 0; b < 8; b++) begin
         for (int r = 0; r < 4; r++) wr(r, (8'h01 << b) & MASK[r]);
         chk_all();
      end
   endtask
   // Large external loop cap: accuracy bit cleared; synth mode paired with free-run,
   // whose state field lives in another block
   task automatic t_soft_duties();
      wr(1, 8'h08);
      chk_all();
   endtask
   task automatic t_unmapped();
      bus(16'h00b0, 8'hff, 1'b1, 1'b0);
      bus(16'h00ab, 8'hff, 1'b1, 1'b0);
      bus(16'h01ac, 8'hff, 1'b1, 1'b0);
      bus(16'h00b0, 8'h00, 1'b0, 1'b1);
      cmp8(rdv, 8'h00);
      bus(16'h00ac, 8'h00, 1'b1, 1'b1);
      cmp8(rdv, ex[0]);
      ex[0] = 8'h00;
      chk_all();
   endtask
   task automatic t_midreset();
      for (int r = 0; r < 4; r++) wr(r, MASK[r] ^ DEFV[r]);
      chk_all();
      RST = 1'b1;
      repeat (2) @(posedge CLK);
      #1 RST = 1'b0;
      t_defaults();
   endtask
   task automatic tally_and_finish();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge CLK);
      #1 RST = 1'b0;
      t_defaults();
      t_codes();
      t_walk();
      t_soft_duties();
      t_unmapped();
      t_midreset();
      tally_and_finish();
   end
   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end
endmodule
